/* src/dsx_keystream_xor.sv */
// double-slot keystream xor stage with apb control and output fifo
//
// Functional notes
// - two 840-bit segments per encrypted field pair
// - control tail: segment 0..39 onto a8..a47
// - other tail: segment 0..39 discarded
// - unprotected: segment 40..839 onto payload 0..799
// - single subfield: 40..807 used, 808..839 unused
// - multi: first subfield 40..103, skip 104..119
// - multi: subfields 1..9 sixty-four bits, sixteen skipped
// - multi: tenth subfield 760..823, 824..839 unused
// - two segments total 1680 bits per frame
// - each bearer encrypted with own keystream
// - transmitter: first field first segment, second second
// - receiver: first field first segment, second second
// - mode per connection applies to all bearers
// - grouped connections share one encryption mode
// - check fields never get keystream applied
// - control plane clear unless routed to enciphered
// - frame keystream is first/second segment pair
//
// The APB register port and the address map were decided locally.
`include "dsx_regs.svh"

module dsx_keystream_xor
    import dsx_pkg::*;
#(
    parameter int NCONN      = 4,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              frame_start,
    input  wire logic              field_start,
    input  wire logic [1:0]        field_fmt,
    input  wire logic              field_tail_ct,
    input  wire logic              field_cplane,
    input  wire logic [1:0]        field_conn,
    input  wire logic              in_valid,
    input  wire logic              in_bit,
    output logic                   in_ready,
    input  wire logic              ks_valid,
    input  wire logic              ks_bit,
    output logic                   ks_ready,
    output logic                   out_valid,
    output logic                   out_bit,
    output logic                   out_last,
    input  wire logic              out_ready
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    // refused at elaboration: the connection field is two bits wide
    if (NCONN < 1 || NCONN > 4) begin : g_bad_nconn
        $error("dsx_keystream_xor: NCONN must be 1 to 4");
    end
    // fewer than two slots cannot keep the stream moving under backpressure
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("dsx_keystream_xor: FIFO_DEPTH must be at least 2");
    end

    // apb registers
    logic [1:0]       ctrl_r;
    logic [NCONN-1:0] conn_mode_r;
    logic             ignored_r;
    logic             ks_over_r;
    logic [15:0]      field_cnt_r;
    logic [31:0]      prdata_r;
    logic             pready_r;
    logic             pslverr_r;

    // field state
    dsx_state_e       state_r;
    dsx_fmt_e         fmt_r;
    logic             tail_ct_r;
    logic             field_enc_r;
    dsx_pos_t         pos_r;
    logic [6:0]       sub_pos_r;
    logic             second_r;
    dsx_ks_cnt_t      frame_ks_r;
    logic             in_ready_r;
    logic             ks_ready_r;

    // output stage
    logic             out_valid_r;
    logic             out_bit_r;
    logic             out_last_r;

    logic             wr_acc;
    logic             setup;
    logic             take;
    logic             in_payload;
    logic             mask_bit;
    logic             last_bit;
    logic             fifo_s_ready;
    logic             fifo_m_valid;
    logic             fifo_m_ready;
    logic [1:0]       fifo_m_data;
    logic [LW-1:0]    fifo_level;
    logic             pop;
    logic [LW:0]      level_nxt;
    logic             start_ok;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready_r && pwrite;

    // apb answer: decode in setup, data ready in the single access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            if (setup) begin
                unique case (paddr)
                    `DSX_OFF_CTRL: begin
                        prdata_r <= {30'h0, ctrl_r};
                    end
                    `DSX_OFF_CONN_MODE: begin
                        prdata_r <= 32'(conn_mode_r);
                    end
                    `DSX_OFF_GROUP_SET: begin
                        prdata_r <= 32'h0000_0000;
                    end
                    `DSX_OFF_STATUS: begin
                        prdata_r <= {28'h0, ks_over_r, ignored_r, second_r, state_r == DSX_RUN};
                    end
                    `DSX_OFF_FIELD_CNT: begin
                        prdata_r <= {16'h0, field_cnt_r};
                    end
                    default: begin
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `DSX_RST_CTRL;
        end else if (wr_acc && paddr == `DSX_OFF_CTRL) begin
            ctrl_r <= pwdata[1:0];
        end
    end

    // one mode bit per connection; the field's connection picks it for every bearer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conn_mode_r <= '0;
        end else if (wr_acc && paddr == `DSX_OFF_CONN_MODE) begin
            conn_mode_r <= pwdata[NCONN-1:0];
        end else if (wr_acc && paddr == `DSX_OFF_GROUP_SET) begin
            // one write moves a whole call's connections together
            for (int c = 0; c < NCONN; c++) begin
                if (pwdata[c]) begin
                    conn_mode_r[c] <= pwdata[`DSX_GROUP_MODE_BIT];
                end
            end
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ignored_r <= 1'b0;
            ks_over_r <= 1'b0;
        end else begin
            if (field_start && !start_ok) begin
                ignored_r <= 1'b1;
            end else if (wr_acc && paddr == `DSX_OFF_STATUS && pwdata[`DSX_ST_IGNORED]) begin
                ignored_r <= 1'b0;
            end
            if (take && frame_ks_r >= dsx_ks_cnt_t'(`DSX_FRAME_KS_BITS)) begin
                ks_over_r <= 1'b1;
            end else if (wr_acc && paddr == `DSX_OFF_STATUS && pwdata[`DSX_ST_KS_OVER]) begin
                ks_over_r <= 1'b0;
            end
        end
    end

    // a field may start only when idle; a new frame restarts the pair
    assign start_ok = (state_r == DSX_IDLE);
    // fifo space checked again so a push can never be lost
    assign take     = (state_r == DSX_RUN) && in_valid && ks_valid && in_ready_r && ks_ready_r && fifo_s_ready;
    assign last_bit = (pos_r == dsx_pos_t'(`DSX_SEG_BITS - 1));
    assign in_payload = (pos_r >= dsx_pos_t'(`DSX_TAIL_BITS));

    // keystream position equals field position: tail bits first, then payload
    always_comb begin
        mask_bit = 1'b0;
        if (!in_payload) begin
            mask_bit = tail_ct_r;
        end else begin
            unique case (fmt_r)
                DSX_UNPROT: begin
                    mask_bit = 1'b1;
                end
                DSX_SINGLE: begin
                    mask_bit = (pos_r < dsx_pos_t'(`DSX_TAIL_BITS + `DSX_SINGLE_BITS));
                end
                DSX_MULTI: begin
                    // sub_pos counts within each 80-bit subfield, check bits skipped
                    mask_bit = (sub_pos_r < 7'(`DSX_SUB_DATA_BITS));
                end
                default: begin
                    mask_bit = 1'b0;
                end
            endcase
        end
        mask_bit = mask_bit && field_enc_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= DSX_IDLE;
            fmt_r       <= DSX_UNPROT;
            tail_ct_r   <= 1'b0;
            field_enc_r <= 1'b0;
            pos_r       <= '0;
            sub_pos_r   <= '0;
        end else begin
            unique case (state_r)
                DSX_IDLE: begin
                    if (field_start) begin
                        // sideband latched ahead of the bits so the mask never stalls
                        state_r   <= DSX_RUN;
                        fmt_r     <= (field_fmt == 2'd3) ? DSX_UNPROT : dsx_fmt_e'(field_fmt);
                        tail_ct_r <= field_tail_ct;
                        // index wraps when fewer connections are built
                        field_enc_r <= ctrl_r[`DSX_CTRL_ENABLE]
                                     && conn_mode_r[int'(field_conn) % NCONN]
                                     && (!field_cplane || ctrl_r[`DSX_CTRL_CP_ROUTE]);
                        pos_r     <= '0;
                        sub_pos_r <= '0;
                    end
                end
                DSX_RUN: begin
                    if (take) begin
                        pos_r <= pos_r + 1'b1;
                        if (in_payload) begin
                            sub_pos_r <= (sub_pos_r == 7'(`DSX_SUB_BITS - 1)) ? '0 : sub_pos_r + 1'b1;
                        end
                        if (last_bit) begin
                            state_r <= DSX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // first field of a frame uses the first segment, second the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_r    <= 1'b0;
            frame_ks_r  <= '0;
            field_cnt_r <= 16'h0000;
        end else begin
            if (frame_start) begin
                second_r   <= 1'b0;
                frame_ks_r <= '0;
            end else begin
                if (take && last_bit) begin
                    second_r <= !second_r;
                end
                if (take && frame_ks_r < dsx_ks_cnt_t'(`DSX_FRAME_KS_BITS)) begin
                    frame_ks_r <= frame_ks_r + 1'b1;
                end
            end
            if (take && last_bit) begin
                field_cnt_r <= field_cnt_r + 1'b1;
            end
        end
    end

    // ready only if the fifo keeps a free slot after this cycle's moves;
    // keystream for each bearer comes from its own generator, one bit per field bit
    assign pop       = fifo_m_valid && fifo_m_ready;
    assign level_nxt = (LW+1)'(fifo_level) + (LW+1)'(take) - (LW+1)'(pop);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_ready_r <= 1'b0;
            ks_ready_r <= 1'b0;
        end else begin
            in_ready_r <= (level_nxt < (LW+1)'(FIFO_DEPTH));
            ks_ready_r <= (level_nxt < (LW+1)'(FIFO_DEPTH));
        end
    end

    // same xor both ways, so one path encrypts and decrypts
    dsx_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .s_valid (take),
        .s_ready (fifo_s_ready),
        .s_data  ({last_bit, in_bit ^ (ks_bit & mask_bit)}),
        .m_valid (fifo_m_valid),
        .m_ready (fifo_m_ready),
        .m_data  (fifo_m_data),
        .level   (fifo_level)
    );

    // registered output stage keeps the ports glitch free
    assign fifo_m_ready = !out_valid_r || out_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_r <= 1'b0;
            out_bit_r   <= 1'b0;
            out_last_r  <= 1'b0;
        end else if (fifo_m_ready) begin
            // an empty fifo loads zeros, never unwritten storage
            out_valid_r <= fifo_m_valid;
            out_bit_r   <= fifo_m_valid && fifo_m_data[0];
            out_last_r  <= fifo_m_valid && fifo_m_data[1];
        end
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign in_ready  = in_ready_r;
    assign ks_ready  = ks_ready_r;
    assign out_valid = out_valid_r;
    assign out_bit   = out_bit_r;
    assign out_last  = out_last_r;
endmodule // dsx_keystream_xor

/* src/dsx_regs.svh */
// register offsets, field positions and stream constants of the keystream xor block
`ifndef DSX_REGS_SVH
`define DSX_REGS_SVH

`define DSX_OFF_CTRL        12'h000
`define DSX_OFF_CONN_MODE   12'h004
`define DSX_OFF_GROUP_SET   12'h008
`define DSX_OFF_STATUS      12'h00C
`define DSX_OFF_FIELD_CNT   12'h010

`define DSX_CTRL_ENABLE     0
`define DSX_CTRL_CP_ROUTE   1
`define DSX_GROUP_MODE_BIT  16
`define DSX_ST_BUSY         0
`define DSX_ST_SECOND       1
`define DSX_ST_IGNORED      2
`define DSX_ST_KS_OVER      3

`define DSX_RST_CTRL        2'h0
`define DSX_SEG_BITS        840
`define DSX_TAIL_BITS       40
`define DSX_PAYLOAD_BITS    800
`define DSX_SINGLE_BITS     768
`define DSX_SUB_BITS        80
`define DSX_SUB_DATA_BITS   64
`define DSX_FRAME_KS_BITS   1680

`endif

/* src/dsx_pkg.sv */
// types shared by the keystream xor block
package dsx_pkg;
    typedef enum logic [1:0] {
        DSX_UNPROT,
        DSX_SINGLE,
        DSX_MULTI
    } dsx_fmt_e;

    typedef enum logic {
        DSX_IDLE,
        DSX_RUN
    } dsx_state_e;

    typedef logic [9:0]  dsx_pos_t;
    typedef logic [10:0] dsx_ks_cnt_t;
endpackage

/* src/dsx_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
module dsx_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       s_valid,
    output logic                            s_ready,
    input  wire logic [WIDTH-1:0]           s_data,
    output logic                            m_valid,
    input  wire logic                       m_ready,
    output logic [WIDTH-1:0]                m_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // refused at elaboration: one slot cannot push and pop in the same cycle
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
        $error("dsx_fifo: DEPTH must be at least 2 and WIDTH at least 1");
    end

    logic [WIDTH-1:0]           mem_r [DEPTH];
    logic [AW-1:0]              wr_r;
    logic [AW-1:0]              rd_r;
    logic [$clog2(DEPTH+1)-1:0] cnt_r;
    logic                       push;
    logic                       pop;

    assign s_ready = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign m_valid = (cnt_r != '0);
    assign m_data  = mem_r[rd_r];
    assign level   = cnt_r;
    assign push    = s_valid && s_ready;
    assign pop     = m_valid && m_ready;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem_r[wr_r] <= s_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // dsx_fifo

/* sim/dsx_keystream_xor_monitor.sv */
// port checker of the keystream xor block, bound to the top module
module dsx_keystream_xor_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        in_ready,
    input wire logic        ks_ready,
    input wire logic        out_valid,
    input wire logic        out_bit,
    input wire logic        out_last,
    input wire logic        out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [9:0] ocnt_r;

    // own bit index, free of out_last so a misplaced marker shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ocnt_r <= '0;
        else if (out_valid && out_ready)
            ocnt_r <= (ocnt_r == 10'd839) ? '0 : ocnt_r + 10'd1;
    end

    ks_pairing_a: assert property (ks_ready == in_ready)
        else $error("keystream ready differs from field ready");
    last_marker_a: assert property (out_valid |-> out_last == (ocnt_r == 10'd839))
        else $error("field end marker on wrong bit");
    last_valid_a: assert property (out_last |-> out_valid)
        else $error("end marker without valid");
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_bit) && $stable(out_last))
        else $error("output changed while stalled");
    ready_delay_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access cycle");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response with data");
endmodule // dsx_keystream_xor_monitor

bind dsx_keystream_xor dsx_keystream_xor_monitor i_mon (.pclk, .presetn, .psel, .penable, .prdata, .pready,
    .pslverr, .in_ready, .ks_ready, .out_valid, .out_bit, .out_last, .out_ready);

/* sim/dsx_peer_sink.sv */
// peer receive model: takes the output bit stream, may stall
module dsx_peer_sink (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow,
    input  wire logic out_valid,
    input  wire logic out_bit,
    input  wire logic out_last,
    output logic      out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       got [840];
    int         n = 0;
    int         fields = 0;
    logic [1:0] ph;

    // slow mode takes one cycle of four so the fifo backs up
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
            ph <= 2'd0;
            n = 0;
        end else begin
            ph <= ph + 2'd1;
            out_ready <= !slow || ph == 2'd3;
            if (out_valid && out_ready) begin
                got[n] = out_bit;
                n = out_last ? 0 : n + 1;
                fields = fields + (out_last ? 1 : 0);
            end
        end
    end
endmodule // dsx_peer_sink

/* sim/tb_dsx_keystream_xor.sv */
// self-checking bench of the keystream xor block
module tb_dsx_keystream_xor;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] f; logic ct, cp; logic [1:0] cn; logic en, fs, dup;} dsx_row_s;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, err, in_ready, ks_ready, out_valid, out_bit, out_last, out_ready;
    logic        frame_start = 0, field_start = 0, field_tail_ct = 0, field_cplane = 0;
    logic        in_valid = 0, in_bit = 0, ks_valid = 0, ks_bit = 0, slow = 0, seg2 = 0;
    logic [1:0]  field_fmt = '0, field_conn = '0;
    int          error_cnt = 0, n_compared = 0, cyc = 0, nf = 0, stall = 0;
    localparam dsx_row_s ROWS [6] = '{'{2'd0, 1, 0, 2'd0, 1, 1, 0}, '{2'd1, 0, 0, 2'd0, 1, 0, 1},
        '{2'd2, 1, 0, 2'd0, 1, 0, 0}, '{2'd3, 1, 0, 2'd0, 1, 1, 0}, '{2'd0, 1, 0, 2'd1, 0, 0, 0},
        '{2'd2, 1, 1, 2'd0, 0, 1, 0}};
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

    always #12.5 pclk = ~pclk;

    dsx_keystream_xor #(.NCONN(4), .FIFO_DEPTH(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .frame_start, .field_start, .field_fmt, .field_tail_ct,
        .field_cplane, .field_conn, .in_valid, .in_bit, .in_ready, .ks_valid, .ks_bit, .ks_ready,
        .out_valid, .out_bit, .out_last, .out_ready);
    dsx_peer_sink i_peer (.pclk, .presetn, .slow, .out_valid, .out_bit, .out_last, .out_ready);

    task automatic give_verdict;
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // waits on pready, a hang is cut by the cycle ceiling
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, '0);
        `CHK("prdata", e, rd)
    endtask

    task automatic run_field(input dsx_row_s r);
        int   p;
        logic e;
        if (r.fs) begin
            frame_start <= 1;
            seg2 = 0;
            @(posedge pclk);
            frame_start <= 0;
        end
        field_start <= 1;
        {field_fmt, field_tail_ct, field_cplane, field_conn} <= {r.f, r.ct, r.cp, r.cn};
        @(posedge pclk);
        in_valid <= 1;
        ks_valid <= 1;
        p = 0;
        while (p < 840) begin
            in_bit <= p[0] ^ p[3];
            ks_bit <= ~p[1];
            field_start <= r.dup && p == 100;
            @(posedge pclk);
            if (in_ready) p++;
            else stall++;
        end
        in_valid <= 0;
        ks_valid <= 0;
        while (i_peer.fields != nf + 1) @(posedge pclk);
        nf++;
        for (p = 0; p < 840; p++) begin
            e = p < 40 ? r.ct : r.f == 2'd1 ? p < 808 : r.f == 2'd2 ? (p - 40) % 80 < 64 : 1'b1;
            `CHK("out_bit", (p[0] ^ p[3]) ^ (~p[1] & r.en & e), i_peer.got[p])
        end
        seg2 = ~seg2;
        apb(0, 12'h00C, '0);
        `CHK("second_segment", seg2, rd[1])
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            give_verdict;
        end
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(1, 12'h000, 32'h0000_0001);
        apb(1, 12'h004, 32'h0000_0001);
        for (int i = 0; i < 6; i++) run_field(ROWS[i]);
        rchk(12'h00C, 32'h0000_000E);
        apb(1, 12'h00C, 32'h0000_000C);
        rchk(12'h00C, 32'h0000_0002);
        apb(1, 12'h000, 32'h0000_0003);
        slow <= 1;
        run_field('{2'd0, 1, 1, 2'd0, 1, 1, 0});
        slow <= 0;
        `CHK("stalled", 1'b1, stall > 0)
        apb(1, 12'h008, 32'h0001_0006);
        rchk(12'h004, 32'h0000_0007);
        apb(1, 12'h008, 32'h0000_0003);
        rchk(12'h004, 32'h0000_0004);
        rchk(12'h008, 32'h0000_0000);
        run_field('{2'd2, 1, 0, 2'd2, 1, 1, 0});
        rchk(12'h010, 32'h0000_0008);
        rchk(12'h020, 32'h0000_0000);
        `CHK("pslverr", 1'b1, err)
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        rchk(12'h000, 32'h0000_0000);
        rchk(12'h004, 32'h0000_0000);
        rchk(12'h00C, 32'h0000_0000);
        rchk(12'h010, 32'h0000_0000);
        give_verdict;
    end
endmodule // tb_dsx_keystream_xor
